// file: src/timer16_core.sv
// 16-bit timer/counter with byte-wide registers behind an AHB-Lite slave.
// Assumes one master, single word transfers, and asynchronous pin inputs.

`default_nettype none

module timer16_core (
    // Clock, reset, enable
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    // AHB-Lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic O_HREADYOUT,
    output logic [31:0] O_HRDATA,
    output logic O_HRESP,
    // Pins
    input wire logic I_EXT_COUNT_PIN,
    input wire logic I_CAPTURE_PIN,
    output logic O_WAVE_OUT_A,
    output logic O_WAVE_OUT_B,
    // Gated requests: overflow, match A, match B, capture
    output logic [3:0] O_IRQ
);
    typedef struct packed {
        // 16-bit values, reached only through the byte window
        logic [15:0] count, cmp_a_buf, cmp_a, cmp_b_buf, cmp_b, cap;
        logic [7:0] latch, ctl_a, ctl_b, rdata, wr_addr, rd_addr;
        logic [3:0] flags, mask, irq, hist;
        logic [timer16_pkg::PSC_W-1:0] psc;
        logic pwr_off, down, blk, ext_s1, ext_s2, ext_prev;
        logic cap_s1, cap_s2, cap_lvl, cap_prev;
        logic wave_a, wave_b, wr_pend, rd_pend, hready;
    } state_t;

    localparam state_t RST_S = '{
        default: '0,
        ctl_a: timer16_pkg::CTL_RST,
        ctl_b: timer16_pkg::CTL_RST,
        pwr_off: timer16_pkg::PWR_RST,
        hready: 1'b1
    };

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic tick_of(input logic [2:0] cs,
            input logic [timer16_pkg::PSC_W-1:0] p,
            input logic e, input logic ep);
        unique case (cs)
            3'h0: tick_of = 1'b0;
            3'h1: tick_of = 1'b1;
            3'h2: tick_of = &p[2:0];
            3'h3: tick_of = &p[5:0];
            3'h4: tick_of = &p[7:0];
            3'h5: tick_of = &p[9:0];
            3'h6: tick_of = ep & ~e;
            3'h7: tick_of = ~ep & e;
        endcase
    endfunction : tick_of

    function automatic logic [15:0] top_of(input logic [3:0] m,
            input logic [15:0] a, input logic [15:0] c);
        unique case (m)
            4'h1, 4'h5: top_of = timer16_pkg::TOP_8;
            4'h2, 4'h6: top_of = timer16_pkg::TOP_9;
            4'h3, 4'h7: top_of = timer16_pkg::TOP_10;
            4'h4, 4'h9, 4'hB, 4'hF: top_of = a;
            4'h8, 4'hA, 4'hC, 4'hE: top_of = c;
            4'h0, 4'hD: top_of = timer16_pkg::MAX;
        endcase
    endfunction : top_of

    state_t s;
    state_t next_s;
    logic [3:0] mode;
    logic pwm, dual, icr_top, a_top, run, tick;
    logic [15:0] top;
    logic match_a, match_b, cap_ev, at_top, accept;
    logic [7:0] wd;

    assign mode = {s.ctl_b[timer16_pkg::WGM_HI_LSB +: 2],
                   s.ctl_a[timer16_pkg::WGM_LO_LSB +: 2]};
    assign pwm = !(mode == 4'h0 || mode == 4'h4 || mode == 4'hC);
    assign dual = (mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
    assign icr_top = (mode inside {4'h8, 4'hA, 4'hC, 4'hE});
    assign a_top = (mode inside {4'h4, 4'h9, 4'hB, 4'hF});
    assign run = !s.pwr_off;
    assign tick = run && tick_of(s.ctl_b[timer16_pkg::CS_LSB +: 3], s.psc,
                                 s.ext_s2, s.ext_prev);
    assign top = top_of(mode, s.cmp_a, s.cap);
    assign at_top = (s.count == top);
    // continuous compare; match on the first tick after a counter write is blocked
    assign match_a = tick && !s.blk && s.count == s.cmp_a;
    assign match_b = tick && !s.blk && s.count == s.cmp_b;
    // capture edge, off in modes where the capture value is top
    assign cap_ev = run && !icr_top && (s.cap_lvl != s.cap_prev) &&
                    (s.cap_lvl == s.ctl_b[timer16_pkg::EDGE_BIT]);
    assign accept = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign wd = I_HWDATA[7:0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Pin synchronisers and prescaler
        next_s.ext_s1 = I_EXT_COUNT_PIN;
        next_s.ext_s2 = s.ext_s1;
        next_s.ext_prev = s.ext_s2;
        next_s.cap_s1 = I_CAPTURE_PIN;
        next_s.cap_s2 = s.cap_s1;
        next_s.cap_prev = s.cap_lvl;
        next_s.hist = {s.hist[2:0], s.cap_s2};
        next_s.psc = run ? s.psc + 1'b1 : '0;
        // four equal samples needed when the filter is on
        if (!s.ctl_b[timer16_pkg::FILT_BIT]) begin
            next_s.cap_lvl = s.cap_s2;
        end else if (s.hist == {timer16_pkg::FILT_SAMPLES{~s.cap_lvl}}) begin
            next_s.cap_lvl = ~s.cap_lvl;
        end

        // Buffered compare values load at top in PWM modes, every cycle otherwise
        // in PWM, top from compare A changes only at the period boundary
        if (!pwm || (tick && at_top)) begin
            next_s.cmp_a = s.cmp_a_buf;
            next_s.cmp_b = s.cmp_b_buf;
        end

        // Counting
        if (tick) begin
            next_s.blk = 1'b0;
            if (dual) begin
                if (!s.down) begin
                    if (at_top) begin
                        next_s.down = 1'b1;
                        next_s.count = s.count - 1'b1;
                    end else begin
                        next_s.count = s.count + 1'b1;
                    end
                end else if (s.count == timer16_pkg::BOTTOM) begin
                    next_s.down = 1'b0;
                    next_s.count = s.count + 1'b1;
                    next_s.flags[timer16_pkg::F_OVF] = 1'b1;
                end else begin
                    next_s.count = s.count - 1'b1;
                end
            end else if (at_top) begin
                next_s.count = timer16_pkg::BOTTOM;
                // overflow at max, or at top in PWM
                if (pwm || s.count == timer16_pkg::MAX) begin
                    next_s.flags[timer16_pkg::F_OVF] = 1'b1;
                end
            end else begin
                next_s.count = s.count + 1'b1;
            end
        end

        // match drives the wave outputs; none on A when A is PWM top
        if (match_a && s.ctl_a[timer16_pkg::OUTA_LSB +: 2] != 2'h0 &&
                !(pwm && a_top)) begin
            next_s.wave_a = ~s.wave_a;
        end
        if (match_b && s.ctl_a[timer16_pkg::OUTB_LSB +: 2] != 2'h0) begin
            next_s.wave_b = ~s.wave_b;
        end

        if (cap_ev) begin
            next_s.cap = s.count;
        end

        // ------------------------------------------------------------
        // Register writes, data phase
        // ------------------------------------------------------------
        if (s.wr_pend) begin
            unique case (s.wr_addr)
                // high-byte writes only reach the latch
                // relies on the high byte arriving first
                timer16_pkg::A_CNT_H, timer16_pkg::A_CMPA_H,
                timer16_pkg::A_CMPB_H, timer16_pkg::A_CAP_H:
                    next_s.latch = wd;
                // low byte write loads both bytes at once
                // overrides any count in this cycle
                timer16_pkg::A_CNT_L: begin
                    next_s.count = {s.latch, wd};
                    next_s.blk = 1'b1;
                end
                timer16_pkg::A_CMPA_L: next_s.cmp_a_buf = {s.latch, wd};
                timer16_pkg::A_CMPB_L: next_s.cmp_b_buf = {s.latch, wd};
                // capture value writable only when it is top
                timer16_pkg::A_CAP_L: begin
                    if (icr_top) begin
                        next_s.cap = {s.latch, wd};
                    end
                end
                timer16_pkg::A_CTL_A: next_s.ctl_a = wd;
                timer16_pkg::A_CTL_B: next_s.ctl_b = wd;
                timer16_pkg::A_CTL_C: begin
                    if (wd[timer16_pkg::FORCE_A] && !(pwm && a_top)) begin
                        next_s.wave_a = ~s.wave_a;
                    end
                    if (wd[timer16_pkg::FORCE_B]) begin
                        next_s.wave_b = ~s.wave_b;
                    end
                end
                timer16_pkg::A_FLAG: next_s.flags = s.flags & ~wd[3:0];
                timer16_pkg::A_MASK: next_s.mask = wd[3:0];
                timer16_pkg::A_PWR: next_s.pwr_off = wd[timer16_pkg::PWR_BIT];
                default: ;
            endcase
        end

        // Match and capture flags set after the clear so a same-cycle event wins
        if (match_a) begin
            next_s.flags[timer16_pkg::F_MA] = 1'b1;
        end
        if (match_b) begin
            next_s.flags[timer16_pkg::F_MB] = 1'b1;
        end
        if (cap_ev) begin
            next_s.flags[timer16_pkg::F_CAP] = 1'b1;
        end
        next_s.irq = next_s.flags & next_s.mask;

        // ------------------------------------------------------------
        // Reads: one wait state, data and side effects at the commit
        // ------------------------------------------------------------
        next_s.hready = 1'b1;
        next_s.wr_pend = 1'b0;
        if (s.rd_pend) begin
            next_s.rd_pend = 1'b0;
            unique case (s.rd_addr)
                // low read copies the high byte into the latch
                timer16_pkg::A_CNT_L: begin
                    next_s.rdata = s.count[7:0];
                    next_s.latch = s.count[15:8];
                end
                timer16_pkg::A_CAP_L: begin
                    next_s.rdata = s.cap[7:0];
                    next_s.latch = s.cap[15:8];
                end
                // one latch for both high locations; order assumed
                timer16_pkg::A_CNT_H, timer16_pkg::A_CAP_H:
                    next_s.rdata = s.latch;
                timer16_pkg::A_CMPA_L: next_s.rdata = s.cmp_a_buf[7:0];
                timer16_pkg::A_CMPA_H: next_s.rdata = s.cmp_a_buf[15:8];
                timer16_pkg::A_CMPB_L: next_s.rdata = s.cmp_b_buf[7:0];
                timer16_pkg::A_CMPB_H: next_s.rdata = s.cmp_b_buf[15:8];
                timer16_pkg::A_CTL_A: next_s.rdata = s.ctl_a;
                timer16_pkg::A_CTL_B: next_s.rdata = s.ctl_b;
                timer16_pkg::A_FLAG: next_s.rdata = {4'h0, s.flags};
                timer16_pkg::A_MASK: next_s.rdata = {4'h0, s.mask};
                timer16_pkg::A_PWR: next_s.rdata = {7'h00, s.pwr_off};
                default: next_s.rdata = 8'h00;
            endcase
        end
        if (accept) begin
            if (I_HWRITE) begin
                next_s.wr_pend = 1'b1;
                next_s.wr_addr = I_HADDR[7:0];
            end else begin
                next_s.rd_pend = 1'b1;
                next_s.rd_addr = I_HADDR[7:0];
                next_s.hready = 1'b0;
            end
        end
    end

    // all value registers and the latch clear on reset
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            s <= RST_S;
        end else if (I_CE) begin
            s <= next_s;
        end
    end

    assign O_HREADYOUT = s.hready;
    assign O_HRDATA = {24'h000000, s.rdata};
    assign O_HRESP = 1'b0;
    assign O_WAVE_OUT_A = s.wave_a;
    assign O_WAVE_OUT_B = s.wave_b;
    assign O_IRQ = s.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    logic wr_cnt_l, rd_cnt_l, rd_cmp, wr_cap_l;
    assign wr_cnt_l = s.wr_pend && s.wr_addr == timer16_pkg::A_CNT_L;
    assign rd_cnt_l = s.rd_pend && s.rd_addr == timer16_pkg::A_CNT_L;
    assign rd_cmp = s.rd_pend && (s.rd_addr inside {timer16_pkg::A_CMPA_L,
        timer16_pkg::A_CMPA_H, timer16_pkg::A_CMPB_L, timer16_pkg::A_CMPB_H});
    assign wr_cap_l = s.wr_pend && s.wr_addr == timer16_pkg::A_CAP_L;

    a_low_write_load: assert property (
        wr_cnt_l && I_CE |=> s.count == $past({s.latch, wd}))
        else $error("counter low write did not load both bytes");
    a_write_beats_count: assert property (
        wr_cnt_l && tick && I_CE |=> s.count == $past({s.latch, wd}))
        else $error("counter write lost against counting");
    a_low_read_latch: assert property (
        rd_cnt_l && I_CE |=> s.latch == $past(s.count[15:8]) &&
                             O_HRDATA[7:0] == $past(s.count[7:0]))
        else $error("low read did not latch the high byte");
    a_cmp_read_keep: assert property (
        rd_cmp && !s.wr_pend && I_CE |=> $stable(s.latch))
        else $error("compare read touched the latch");
    a_power_freeze: assert property (
        s.pwr_off && !s.wr_pend |=> $stable(s.count) && !$rose(s.flags[0]))
        else $error("timer moved while powered off");
    a_no_source: assert property (
        s.ctl_b[2:0] == 3'h0 && !s.wr_pend |=> $stable(s.count))
        else $error("counter moved with no clock source");
    a_match_flag: assert property (
        match_a && I_CE |=> s.flags[timer16_pkg::F_MA])
        else $error("match did not set its flag");
    a_capture_copy: assert property (
        cap_ev && !wr_cap_l && I_CE |=> s.flags[timer16_pkg::F_CAP] &&
                                         s.cap == $past(s.count))
        else $error("capture copy and flag not together");
    a_cap_write_guard: assert property (
        wr_cap_l && !icr_top && !cap_ev |=> $stable(s.cap))
        else $error("capture value written outside top modes");
    a_top_wrap: assert property (
        tick && !dual && at_top && !s.wr_pend && I_CE |=> s.count == 16'h0000)
        else $error("single slope count did not wrap at top");
    a_irq_gate: assert property (
        O_IRQ == (s.flags & s.mask))
        else $error("request passed a cleared mask bit");
    a_read_wait: assert property (
        accept && !I_HWRITE && I_CE ##1 I_CE |=> O_HREADYOUT)
        else $error("read answer late");

    c_capture: cover property (cap_ev);
    c_overflow: cover property ($rose(s.flags[timer16_pkg::F_OVF]));
    c_read_pair: cover property (rd_cnt_l ##[1:8] s.rd_pend &&
                                 s.rd_addr == timer16_pkg::A_CNT_H);
    c_match_b: cover property (match_b);
endmodule : timer16_core

`default_nettype wire

// file: src/timer16_pkg.sv
// Constants for the 16-bit timer core with its byte-wide register window.
// Assumes a single AHB-Lite master and one 25 MHz system clock.
//
// Overview of operation
// - Timer stays frozen while the power-off bit is one; runs once cleared.
// - Counter, compare and capture values are 16 bits, reached byte-wise.
// - Control registers A and B are 8 bits with plain reads and writes; C holds strobes and reads zero.
// - Every request shows in the flag register and is gated by a mask bit.
// - Tick comes from prescaler or external pin edge; none selected, no count.
// - Buffered compare values checked continuously; match sets flag, drives wave.
// - Qualifying capture-pin edge copies counter; optional filter kills spikes.
// - Top is FFFF, 00FF, 01FF, 03FF, compare value A or capture value, by mode.
// - Compare A as PWM top gives no PWM on channel A, top stays buffered.
// - Zero is bottom and FFFF is maximum for limit events.
// - One shared 8-bit high-byte latch serves all 16-bit registers.
// - Low-byte access does the 16-bit transfer; high-byte access hits latch, except compare reads.
// - Low-byte write loads latch and written byte together in one cycle.
// - Low-byte read copies the high byte into the latch in the same cycle.
// - Compare reads return both bytes directly and leave the latch alone.
// - A counter write beats any clear or count in the same cycle.
// - Capture value takes writes only in modes using it as top.
// - Capture flag sets in the same cycle as the capture copy.

`default_nettype none

package timer16_pkg;
    // ------------------------------------------------------------
    // Register byte addresses, one word each, data in bits 7:0
    // ------------------------------------------------------------
    localparam logic [7:0] A_CNT_L = 8'h00;
    localparam logic [7:0] A_CNT_H = 8'h04;
    localparam logic [7:0] A_CMPA_L = 8'h08;
    localparam logic [7:0] A_CMPA_H = 8'h0C;
    localparam logic [7:0] A_CMPB_L = 8'h10;
    localparam logic [7:0] A_CMPB_H = 8'h14;
    localparam logic [7:0] A_CAP_L = 8'h18;
    localparam logic [7:0] A_CAP_H = 8'h1C;
    localparam logic [7:0] A_CTL_A = 8'h20;
    localparam logic [7:0] A_CTL_B = 8'h24;
    localparam logic [7:0] A_CTL_C = 8'h28;
    localparam logic [7:0] A_FLAG = 8'h2C;
    localparam logic [7:0] A_MASK = 8'h30;
    localparam logic [7:0] A_PWR = 8'h34;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CS_LSB = 0;      // control_reg_b [2:0] clock select
    localparam int WGM_HI_LSB = 3;  // control_reg_b [4:3] mode bits 3:2
    localparam int EDGE_BIT = 6;    // control_reg_b capture edge, 1 = rise
    localparam int FILT_BIT = 7;    // control_reg_b capture filter on
    localparam int WGM_LO_LSB = 0;  // control_reg_a [1:0] mode bits 1:0
    localparam int OUTB_LSB = 4;    // control_reg_a [5:4] channel B out
    localparam int OUTA_LSB = 6;    // control_reg_a [7:6] channel A out
    localparam int FORCE_B = 6;     // control_reg_c strobe
    localparam int FORCE_A = 7;     // control_reg_c strobe
    localparam int F_OVF = 0;
    localparam int F_MA = 1;
    localparam int F_MB = 2;
    localparam int F_CAP = 3;
    localparam int PWR_BIT = 0;

    // ------------------------------------------------------------
    // Values and reset states
    // ------------------------------------------------------------
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8 = 16'h00FF;
    localparam logic [15:0] TOP_9 = 16'h01FF;
    localparam logic [15:0] TOP_10 = 16'h03FF;
    localparam logic PWR_RST = 1'b0;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam int FILT_SAMPLES = 4;
    localparam int PSC_W = 10;
endpackage : timer16_pkg

`default_nettype wire

// file: verification/cpu_bus_model.sv
// AHB-Lite master standing in for the 8-bit CPU core.
// Assumes one slave whose hreadyout is looped back as hready.
`default_nettype none

module cpu_bus_model (
    // Clock and slave answer
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    // Request
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h00000000;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h00000000;
    end

    // single master, one byte access at a time
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
        o_hsel <= 1'b1;
        o_haddr <= {24'h000000, a};
        o_htrans <= 2'h2;
        o_hwrite <= w;
        o_hsize <= 3'h2;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= {24'h000000, d};
        do @(posedge i_clk); while (i_hready !== 1'b1);
        q = i_hrdata[7:0];
        // Stale write data must not look valid after the phase
        o_hwdata <= ~{24'h000000, d};
    endtask : xfer

    // high byte first, low byte commits
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        logic [7:0] q;
        xfer(a + 8'h04, 1'b1, v[15:8], q);
        xfer(a, 1'b1, v[7:0], q);
    endtask : wr16

    // low byte first, high byte from the latch
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [7:0] q;
        xfer(a, 1'b0, 8'h00, q);
        v[7:0] = q;
        xfer(a + 8'h04, 1'b0, 8'h00, q);
        v[15:8] = q;
    endtask : rd16
endmodule : cpu_bus_model

`default_nettype wire

// file: verification/timer16_core_and_byte_access_tb_top.sv
// Self-checking bench for the timer core over its byte register window.
// Assumes the CPU model drives the bus; pins driven here.
`default_nettype none

module timer16_core_and_byte_access_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rst_n;
    logic cap;
    logic ext;
    logic hsel;
    logic hwrite;
    logic rdy;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [3:0] irq;
    logic ce;
    logic hresp;
    logic wave_a;
    logic wave_b;
    int bad_count = 0;
    int n_checks = 0;

    timer16_core u_timer16_core (.I_CLK(clk), .I_RST_N(rst_n),
        .I_CE(ce), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
        .I_HREADY(rdy), .O_HREADYOUT(rdy), .O_HRDATA(hrdata),
        .O_HRESP(hresp), .I_EXT_COUNT_PIN(ext), .I_CAPTURE_PIN(cap),
        .O_WAVE_OUT_A(wave_a), .O_WAVE_OUT_B(wave_b), .O_IRQ(irq));

    cpu_bus_model u_cpu_bus_model (.i_clk(clk), .i_hready(rdy),
        .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
        .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_cpu_bus_model.xfer(a, 1'b1, d, q);
    endtask : wb

    task automatic rb(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_cpu_bus_model.xfer(a, 1'b0, 8'h00, q);
        chk({8'h00, q}, {8'h00, e});
    endtask : rb

    task automatic w16(input logic [7:0] a, input logic [15:0] d);
        u_cpu_bus_model.wr16(a, d);
    endtask : w16

    task automatic r16(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        u_cpu_bus_model.rd16(a, q);
        chk(q, e);
    endtask : r16

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        cap = 1'b0;
        ext = 1'b0;
        ce = 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        r16(timer16_pkg::A_CNT_L, 16'h0000);
        r16(timer16_pkg::A_CAP_L, 16'h0000);
        w16(timer16_pkg::A_CNT_L, 16'h01FF);
        r16(timer16_pkg::A_CNT_L, 16'h01FF);
        w16(timer16_pkg::A_CMPA_L, 16'hA55A);
        rb(timer16_pkg::A_CNT_L, 8'hFF);
        rb(timer16_pkg::A_CMPA_H, 8'hA5);
        rb(timer16_pkg::A_CNT_H, 8'h01);
        wb(timer16_pkg::A_CNT_H, 8'h77);
        wb(timer16_pkg::A_CMPB_L, 8'h34);
        r16(timer16_pkg::A_CNT_L, 16'h01FF);
        r16(timer16_pkg::A_CMPB_L, 16'h7734);
        // Capture value is read-only outside the capture-top modes
        w16(timer16_pkg::A_CAP_L, 16'h1234);
        r16(timer16_pkg::A_CAP_L, 16'h0000);
        wb(timer16_pkg::A_CTL_B, 8'h18);
        rb(timer16_pkg::A_CTL_B, 8'h18);
        w16(timer16_pkg::A_CAP_L, 16'h1234);
        r16(timer16_pkg::A_CAP_L, 16'h1234);
        wb(timer16_pkg::A_CTL_B, 8'h00);
        // Powered off: running clock select must not move the count
        wb(timer16_pkg::A_PWR, 8'h01);
        w16(timer16_pkg::A_CNT_L, 16'hFFF0);
        wb(timer16_pkg::A_CTL_B, 8'h01);
        repeat (20) @(posedge clk);
        r16(timer16_pkg::A_CNT_L, 16'hFFF0);
        w16(timer16_pkg::A_CMPB_L, 16'h0005);
        wb(timer16_pkg::A_PWR, 8'h00);
        repeat (60) @(posedge clk);
        wb(timer16_pkg::A_CTL_B, 8'h00);
        rb(timer16_pkg::A_FLAG, 8'h05);
        chk({12'h000, irq}, 16'h0000);
        wb(timer16_pkg::A_MASK, 8'h05);
        repeat (3) @(posedge clk);
        chk({12'h000, irq}, 16'h0005);
        wb(timer16_pkg::A_FLAG, 8'h01);
        rb(timer16_pkg::A_FLAG, 8'h04);
        repeat (3) @(posedge clk);
        chk({12'h000, irq}, 16'h0004);
        // Capture of a stopped count on a rising pin edge
        wb(timer16_pkg::A_FLAG, 8'h0F);
        w16(timer16_pkg::A_CNT_L, 16'h4321);
        wb(timer16_pkg::A_CTL_B, 8'h40);
        cap <= 1'b1;
        repeat (10) @(posedge clk);
        r16(timer16_pkg::A_CAP_L, 16'h4321);
        rb(timer16_pkg::A_FLAG, 8'h08);
        // Clock enable low freezes a running count
        w16(timer16_pkg::A_CNT_L, 16'h1000);
        wb(timer16_pkg::A_CTL_B, 8'h01);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        wb(timer16_pkg::A_CTL_B, 8'h00);
        r16(timer16_pkg::A_CNT_L, 16'h1002);
        // Three rising edges on the external count pin
        wb(timer16_pkg::A_CTL_B, 8'h07);
        repeat (3) begin
            ext <= 1'b1;
            repeat (2) @(posedge clk);
            ext <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        wb(timer16_pkg::A_CTL_B, 8'h00);
        r16(timer16_pkg::A_CNT_L, 16'h1005);
        // Forced toggles, then a match on channel B
        wb(timer16_pkg::A_CTL_A, 8'hF0);
        wb(timer16_pkg::A_CTL_C, 8'hC0);
        @(posedge clk);
        chk({14'h0000, wave_a, wave_b}, 16'h0003);
        w16(timer16_pkg::A_CMPB_L, 16'h1007);
        wb(timer16_pkg::A_CTL_B, 8'h01);
        repeat (5) @(posedge clk);
        wb(timer16_pkg::A_CTL_B, 8'h00);
        chk({14'h0000, wave_a, wave_b}, 16'h0002);
        rb(timer16_pkg::A_FLAG, 8'h0C);
        rb(timer16_pkg::A_CTL_C, 8'h00);
        rb(8'h3C, 8'h00);
        chk({15'h0000, hresp}, 16'h0000);
        // Mid-run reset clears values and the shared latch
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rb(timer16_pkg::A_CNT_H, 8'h00);
        r16(timer16_pkg::A_CNT_L, 16'h0000);
        r16(timer16_pkg::A_CMPA_L, 16'h0000);
        close_out();
    end
endmodule : timer16_core_and_byte_access_tb_top

`default_nettype wire
